/* File: rtl/fifo_pair_cfg.svh */
// Constants of the radio data buffer pair and its host controller.
// Assumes inclusion by bare name from rtl/; holds definitions only.
`ifndef FIFO_PAIR_CFG_SVH
`define FIFO_PAIR_CFG_SVH

// Buffer geometry
`define FIFO_DEPTH      7'h40
`define FIFO_PTR_W      6
`define FIFO_CNT_W      7
`define FIFO_CNT_ZERO   7'h00
`define FIFO_PTR_STEP   6'h01
`define FIFO_CNT_STEP   7'h01

// Threshold coding
`define THR_STEP        7'h04
`define THR_RX_OFFSET   7'h01
`define THR_TX_BASE     7'h3D

// Status byte error bit
`define STAT_ERR_BIT    7

// Flush mask bits carried in the access data
`define FLUSH_RX_BIT    0
`define FLUSH_TX_BIT    1

// Host register offsets
`define REG_TX_DATA     4'h0
`define REG_RX_DATA     4'h1
`define REG_RX_COUNT    4'h2
`define REG_TX_COUNT    4'h3
`define REG_CONFIG      4'h4
`define REG_COMMAND     4'h5
`define REG_IRQ_STATUS  4'h6
`define REG_IRQ_MASK    4'h7
`define REG_STATUS_BYTE 4'h8

// Configuration register fields
`define CFG_THR_LSB     0
`define CFG_THR_MSB     3
`define CFG_PIN_LSB     4
`define CFG_PIN_MSB     5
`define CFG_RESET       8'h00

// Interrupt bits
`define IRQ_RX_OVERFLOW  0
`define IRQ_TX_UNDERFLOW 1
`define IRQ_RX_THR_RISE  2
`define IRQ_TX_THR_FALL  3
`define IRQ_W            4

`endif

/* File: rtl/fifo_pair_pkg.sv */
// Types shared by both ends of the radio data buffer link.
// Assumes nothing beyond a SystemVerilog compiler.
package fifo_pair_pkg;

  // Kind of host access carried over the link
  typedef enum logic [1:0] {
    ACC_TX_DATA,
    ACC_RX_DATA,
    ACC_FLUSH
  } access_target_type;

  // Source routed onto the general output pin
  typedef enum logic [1:0] {
    PIN_RX_THRESHOLD,
    PIN_TX_THRESHOLD,
    PIN_RX_OVERFLOW,
    PIN_TX_UNDERFLOW
  } pin_source_type;

endpackage

/* File: rtl/fifo_link_if.sv */
// Link between the host controller and the buffer pair.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
`default_nettype none
interface fifo_link_if
  import fifo_pair_pkg::*;
();
  // Host to device
  logic                    acc_valid;               // One-cycle access strobe
  access_target_type       acc_target;              // What the access does
  logic [7:0]              acc_wdata;               // Byte to queue or flush mask
  logic [3:0]              buffer_threshold_select; // Threshold point, level
  pin_source_type          pin_source;              // Pin source, level
  // Device to host
  logic [7:0]              acc_rdata;               // Byte popped by last read
  logic [7:0]              status_byte;             // Status of last access
  logic [6:0]              rx_fill_count;           // Receive byte count
  logic [6:0]              tx_fill_count;           // Transmit byte count
  logic                    rx_threshold;            // Receive at or above threshold
  logic                    tx_threshold;            // Transmit at or above threshold
  logic                    rx_overflow_evt;         // One-cycle overflow pulse
  logic                    tx_underflow_evt;        // One-cycle underflow pulse

  modport device (
    input  acc_valid, acc_target, acc_wdata, buffer_threshold_select, pin_source,
    output acc_rdata, status_byte, rx_fill_count, tx_fill_count,
    output rx_threshold, tx_threshold, rx_overflow_evt, tx_underflow_evt
  );

  modport host (
    output acc_valid, acc_target, acc_wdata, buffer_threshold_select, pin_source,
    input  acc_rdata, status_byte, rx_fill_count, tx_fill_count,
    input  rx_threshold, tx_threshold, rx_overflow_evt, tx_underflow_evt
  );
endinterface
`default_nettype wire

/* File: rtl/radio_data_fifo_pair.sv */
// Receive and transmit byte buffers between the radio packet engine
// and the host link, with error flags, counts and threshold signals.
// Assumes the radio side strobes are synchronous to core_clk.
`include "fifo_pair_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module radio_data_fifo_pair
  import fifo_pair_pkg::*;
(
  // Clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   arst_n,
  // Radio receive side
  input  wire logic                   rx_write,
  input  wire logic [7:0]             rx_write_data,
  // Radio transmit side
  input  wire logic                   tx_read,
  output logic      [7:0]             tx_read_data,
  output logic                        tx_empty,
  // Power state
  input  wire logic                   sleep_enter,
  // Programmable output
  output logic                        general_output_pin,
  // Host link
  fifo_link_if.device                 link
);

  // Receive buffer storage and pointers
  logic [7:0]               rx_mem [0:`FIFO_DEPTH-1];
  logic [`FIFO_PTR_W-1:0]   rx_wr_ptr;      // Next slot the radio fills
  logic [`FIFO_PTR_W-1:0]   rx_rd_ptr;      // Next slot the host drains
  logic [`FIFO_CNT_W-1:0]   rx_count;       // Bytes held

  // Transmit buffer storage and pointers
  logic [7:0]               tx_mem [0:`FIFO_DEPTH-1];
  logic [`FIFO_PTR_W-1:0]   tx_wr_ptr;      // Next slot the host fills
  logic [`FIFO_PTR_W-1:0]   tx_rd_ptr;      // Next slot the radio drains
  logic [`FIFO_CNT_W-1:0]   tx_count;       // Bytes held

  // Sticky error flags
  logic                     rx_overflow;    // Radio wrote into a full buffer
  logic                     tx_underflow;   // Radio read an empty buffer

  // Decoded host accesses
  logic                     host_rx_read;   // Host pops a receive byte
  logic                     host_tx_write;  // Host queues a transmit byte
  logic                     flush_rx;       // Host empties receive buffer
  logic                     flush_tx;       // Host empties transmit buffer

  // Push and pop qualifiers
  logic                     rx_full;
  logic                     rx_has_data;
  logic                     tx_full;
  logic                     rx_push;
  logic                     rx_pop;
  logic                     tx_push;
  logic                     tx_pop;
  logic                     rx_over_evt;
  logic                     tx_under_evt;

  // Threshold points
  logic [`FIFO_CNT_W-1:0]   rx_thr;
  logic [`FIFO_CNT_W-1:0]   tx_thr;
  logic [`FIFO_CNT_W-1:0]   thr_scaled;

  // Access decode from the link; host reads, writes and flushes of the buffers
  always_comb
  begin
    host_rx_read  = link.acc_valid && (link.acc_target == ACC_RX_DATA);
    host_tx_write = link.acc_valid && (link.acc_target == ACC_TX_DATA);
    flush_rx      = link.acc_valid && (link.acc_target == ACC_FLUSH) && link.acc_wdata[`FLUSH_RX_BIT];
    flush_tx      = link.acc_valid && (link.acc_target == ACC_FLUSH) && link.acc_wdata[`FLUSH_TX_BIT];
  end

  // Fill conditions and qualified moves
  always_comb
  begin
    rx_full      = (rx_count == `FIFO_DEPTH);
    rx_has_data  = (rx_count != `FIFO_CNT_ZERO);
    tx_full      = (tx_count == `FIFO_DEPTH);
    tx_empty     = (tx_count == `FIFO_CNT_ZERO);
    rx_push      = rx_write && !rx_full;
    rx_over_evt  = rx_write && rx_full;
    rx_pop       = host_rx_read && rx_has_data;
    // A write into a full transmit buffer overwrites the oldest slot
    tx_push      = host_tx_write;
    tx_pop       = tx_read && !tx_empty;
    tx_under_evt = tx_read && tx_empty;
  end

  // Receive storage: written by the radio only
  always_ff @(posedge core_clk)
  begin
    if (rx_push)
    begin
      rx_mem[rx_wr_ptr] <= rx_write_data;
    end
  end

  // Receive pointers and count; sleep or flush restart empty
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_wr_ptr <= '0;
      rx_rd_ptr <= '0;
      rx_count  <= `FIFO_CNT_ZERO;
    end
    else if (sleep_enter || flush_rx)
    begin
      rx_wr_ptr <= '0;
      rx_rd_ptr <= '0;
      rx_count  <= `FIFO_CNT_ZERO;
    end
    else
    begin
      // Simultaneous push and pop on the last byte keeps the count exact
      if (rx_push)
        rx_wr_ptr <= rx_wr_ptr + `FIFO_PTR_STEP;
      if (rx_pop)
        rx_rd_ptr <= rx_rd_ptr + `FIFO_PTR_STEP;
      if (rx_push && !rx_pop)
        rx_count <= rx_count + `FIFO_CNT_STEP;
      else if (rx_pop && !rx_push)
        rx_count <= rx_count - `FIFO_CNT_STEP;
    end
  end

  // Transmit storage: written by the host only
  always_ff @(posedge core_clk)
  begin
    if (tx_push)
    begin
      tx_mem[tx_wr_ptr] <= link.acc_wdata;
    end
  end

  // Transmit pointers and count; an overfill keeps the count at full
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_wr_ptr <= '0;
      tx_rd_ptr <= '0;
      tx_count  <= `FIFO_CNT_ZERO;
    end
    else if (sleep_enter || flush_tx)
    begin
      tx_wr_ptr <= '0;
      tx_rd_ptr <= '0;
      tx_count  <= `FIFO_CNT_ZERO;
    end
    else
    begin
      if (tx_push)
        tx_wr_ptr <= tx_wr_ptr + `FIFO_PTR_STEP;
      if (tx_pop)
        tx_rd_ptr <= tx_rd_ptr + `FIFO_PTR_STEP;
      if (tx_push && !tx_pop && !tx_full)
        tx_count <= tx_count + `FIFO_CNT_STEP;
      else if (tx_pop && !tx_push)
        tx_count <= tx_count - `FIFO_CNT_STEP;
    end
  end

  // Byte handed to the radio transmitter
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      tx_read_data <= 8'h00;
    else if (tx_pop)
      tx_read_data <= tx_mem[tx_rd_ptr];
  end

  // Byte returned to the host; an empty read repeats the last byte
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      link.acc_rdata <= 8'h00;
    else if (rx_pop)
      link.acc_rdata <= rx_mem[rx_rd_ptr];
  end

  // Sticky errors: a new event wins over a flush in the same cycle
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_overflow  <= 1'b0;
      tx_underflow <= 1'b0;
    end
    else
    begin
      if (rx_over_evt)
        rx_overflow <= 1'b1;
      else if (flush_rx || sleep_enter)
        rx_overflow <= 1'b0;
      if (tx_under_evt)
        tx_underflow <= 1'b1;
      else if (flush_tx || sleep_enter)
        tx_underflow <= 1'b0;
    end
  end

  // Error event pulses toward the host
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      link.rx_overflow_evt  <= 1'b0;
      link.tx_underflow_evt <= 1'b0;
    end
    else
    begin
      link.rx_overflow_evt  <= rx_over_evt;
      link.tx_underflow_evt <= tx_under_evt;
    end
  end

  // Status byte: receive level for reads, transmit level otherwise
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      link.status_byte <= 8'h00;
    else if (link.acc_valid)
    begin
      if (link.acc_target == ACC_RX_DATA)
        link.status_byte <= {rx_overflow, rx_count};
      else
        link.status_byte <= {tx_underflow, tx_count};
    end
  end

  // Separate count fields for the host
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      link.rx_fill_count <= `FIFO_CNT_ZERO;
      link.tx_fill_count <= `FIFO_CNT_ZERO;
    end
    else
    begin
      link.rx_fill_count <= rx_count;
      link.tx_fill_count <= tx_count;
    end
  end

  // Threshold points, coded in opposite directions
  always_comb
  begin
    thr_scaled = 7'({3'h0, link.buffer_threshold_select} * `THR_STEP);
    rx_thr     = thr_scaled + `THR_STEP;
    tx_thr     = `THR_TX_BASE - thr_scaled;
  end

  // Threshold flags follow the counts both up and down
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      link.rx_threshold <= 1'b0;
      link.tx_threshold <= 1'b0;
    end
    else
    begin
      link.rx_threshold <= (rx_count >= rx_thr);
      link.tx_threshold <= (tx_count >= tx_thr);
    end
  end

  // Source selection for the general output pin
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      general_output_pin <= 1'b0;
    else
    begin
      unique case (link.pin_source)
        PIN_RX_THRESHOLD: general_output_pin <= (rx_count >= rx_thr);
        PIN_TX_THRESHOLD: general_output_pin <= (tx_count >= tx_thr);
        PIN_RX_OVERFLOW:  general_output_pin <= rx_overflow;
        PIN_TX_UNDERFLOW: general_output_pin <= tx_underflow;
      endcase
    end
  end

endmodule
`default_nettype wire

/* File: rtl/fifo_host_ctrl.sv */
// Host end: turns a plain register port into link accesses and
// collects buffer events into a masked interrupt.
// Assumes the register master keeps to one strobe per cycle.
`include "fifo_pair_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module fifo_host_ctrl
  import fifo_pair_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [7:0]  reg_rdata,
  // Interrupt
  output logic             irq,
  // Link to the buffer pair
  fifo_link_if.host        link
);

  logic [7:0]           config_reg;    // Threshold select and pin source
  logic [`IRQ_W-1:0]    irq_status;    // Sticky events
  logic [`IRQ_W-1:0]    irq_mask;      // Enables onto irq
  logic [`IRQ_W-1:0]    irq_event;     // Events this cycle
  logic [7:0]           local_rdata;   // Registered local read value
  logic                 rdata_is_link; // Last read addressed receive data, empty or not
  logic                 rx_thr_prev;   // Edge detection history
  logic                 tx_thr_prev;

  // Link accesses straight from the strobes; host loads, drains and flushes
  always_comb
  begin
    link.acc_valid  = 1'b0;
    link.acc_target = ACC_TX_DATA;
    link.acc_wdata  = reg_wdata;
    if (reg_write && reg_addr == `REG_TX_DATA)
      link.acc_valid = 1'b1;
    else if (reg_read && reg_addr == `REG_RX_DATA)
    begin
      link.acc_valid  = 1'b1;
      link.acc_target = ACC_RX_DATA;
    end
    else if (reg_write && reg_addr == `REG_COMMAND)
    begin
      link.acc_valid  = 1'b1;
      link.acc_target = ACC_FLUSH;
    end
  end

  // Configuration levels to the device
  assign link.buffer_threshold_select = config_reg[`CFG_THR_MSB:`CFG_THR_LSB];
  assign link.pin_source              = pin_source_type'(config_reg[`CFG_PIN_MSB:`CFG_PIN_LSB]);

  // Configuration and mask registers
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      config_reg <= `CFG_RESET;
      irq_mask   <= '0;
    end
    else if (reg_write)
    begin
      if (reg_addr == `REG_CONFIG)
        config_reg <= reg_wdata;
      if (reg_addr == `REG_IRQ_MASK)
        irq_mask <= reg_wdata[`IRQ_W-1:0];
    end
  end

  // Events from the device, threshold edges detected here
  always_comb
  begin
    irq_event                    = '0;
    irq_event[`IRQ_RX_OVERFLOW]  = link.rx_overflow_evt;
    irq_event[`IRQ_TX_UNDERFLOW] = link.tx_underflow_evt;
    irq_event[`IRQ_RX_THR_RISE]  = link.rx_threshold && !rx_thr_prev;
    irq_event[`IRQ_TX_THR_FALL]  = !link.tx_threshold && tx_thr_prev;
  end

  // Threshold history
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_thr_prev <= 1'b0;
      tx_thr_prev <= 1'b0;
    end
    else
    begin
      rx_thr_prev <= link.rx_threshold;
      tx_thr_prev <= link.tx_threshold;
    end
  end

  // Sticky status, write one to clear, a new event wins
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      irq_status <= '0;
    else if (reg_write && reg_addr == `REG_IRQ_STATUS)
      irq_status <= (irq_status & ~reg_wdata[`IRQ_W-1:0]) | irq_event;
    else
      irq_status <= irq_status | irq_event;
  end

  // Level interrupt
  assign irq = |(irq_status & irq_mask);

  // Read data, one cycle after the strobe
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      local_rdata   <= 8'h00;
      rdata_is_link <= 1'b0;
    end
    else
    begin
      rdata_is_link <= reg_read && reg_addr == `REG_RX_DATA;
      local_rdata   <= 8'h00;
      if (reg_read)
      begin
        unique case (reg_addr)
          `REG_RX_COUNT:    local_rdata <= {1'b0, link.rx_fill_count};
          `REG_TX_COUNT:    local_rdata <= {1'b0, link.tx_fill_count};
          `REG_CONFIG:      local_rdata <= config_reg;
          `REG_IRQ_STATUS:  local_rdata <= {4'h0, irq_status};
          `REG_IRQ_MASK:    local_rdata <= {4'h0, irq_mask};
          `REG_STATUS_BYTE: local_rdata <= link.status_byte;
          default:          local_rdata <= 8'h00;
        endcase
      end
    end
  end

  // Receive data comes straight from the device flop
  assign reg_rdata = rdata_is_link ? link.acc_rdata : local_rdata;

endmodule
`default_nettype wire

/* File: tb/fifo_pair_monitor.sv */
// Concurrent checks on the link between the host end and the buffer pair.
// Assumes one clock domain; instantiated beside the link interface.
`timescale 1ns/1ps
`default_nettype none
module fifo_pair_monitor
  import fifo_pair_pkg::*;
(
  // Clock and reset
  input wire logic              core_clk,
  input wire logic              arst_n,
  // Host to device
  input wire logic              acc_valid,
  input wire access_target_type acc_target,
  input wire logic [7:0]        acc_wdata,
  input wire logic [3:0]        buffer_threshold_select,
  // Device to host
  input wire logic [7:0]        status_byte,
  input wire logic [6:0]        rx_fill_count,
  input wire logic [6:0]        tx_fill_count,
  input wire logic              rx_threshold,
  input wire logic              tx_threshold,
  input wire logic              rx_overflow_evt,
  input wire logic              tx_underflow_evt
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  // Counts never pass the depth
  rx_depth_cap_a: assert property (rx_fill_count <= 7'h40)
    else $error("rx count above depth");
  tx_depth_cap_a: assert property (tx_fill_count <= 7'h40)
    else $error("tx count above depth");
  // Flags follow count against the selected point, both ways
  rx_thr_level_a: assert property (rx_threshold ==
    (rx_fill_count >= (({3'h0, $past(buffer_threshold_select)} + 7'h01) << 2)))
    else $error("rx threshold flag wrong");
  tx_thr_level_a: assert property (tx_threshold ==
    (tx_fill_count >= (7'h3D - ({3'h0, $past(buffer_threshold_select)} << 2))))
    else $error("tx threshold flag wrong");
  // Error pulses only at the buffer limits
  rx_overflow_full_a: assert property (rx_overflow_evt |-> rx_fill_count == 7'h40)
    else $error("overflow while not full");
  tx_underflow_empty_a: assert property (tx_underflow_evt |-> tx_fill_count == 7'h00)
    else $error("underflow while not empty");
  // Status byte carries the receive level after reads, the transmit level after writes and flushes
  rx_status_level_a: assert property (
    acc_valid && acc_target == ACC_RX_DATA |=> status_byte[6:0] == rx_fill_count)
    else $error("status level on read wrong");
  tx_status_level_a: assert property (
    acc_valid && acc_target != ACC_RX_DATA |=> status_byte[6:0] == tx_fill_count)
    else $error("status level on write wrong");
  // Flush empties the receive count two cycles on
  rx_flush_empty_a: assert property (
    acc_valid && acc_target == ACC_FLUSH && acc_wdata[0] |-> ##2 rx_fill_count == 7'h00)
    else $error("rx count not cleared by flush");

  // Main scenarios reached
  cover property (rx_overflow_evt);
  cover property (tx_underflow_evt);
  cover property ($rose(rx_threshold));
  cover property ($fell(tx_threshold));
endmodule
`default_nettype wire

/* File: tb/radio_data_fifo_pair_tb.sv */
// Bench joining the host end and the buffer pair over the link.
// Assumes the register map of the shared cfg header and a 200 MHz clock.
`include "fifo_pair_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module radio_data_fifo_pair_tb
  import fifo_pair_pkg::*;
;
  logic       core_clk = 1'b0;      // Core clock
  logic       arst_n = 1'b0;        // Reset, active low
  logic [3:0] reg_addr = 4'h0;      // Register port
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_write = 1'b0;
  logic       reg_read = 1'b0;
  logic       rx_write = 1'b0;      // Radio side
  logic [7:0] rx_write_data = 8'h00;
  logic       tx_read = 1'b0;
  logic       sleep_enter = 1'b0;
  wire  logic [7:0] reg_rdata;      // Design outputs
  wire  logic [7:0] tx_read_data;
  wire  logic irq, tx_empty, general_output_pin;
  int         err_count = 0;        // Mismatches
  int         checks = 0;           // Comparisons
  int         cyc = 0;              // Watchdog
  logic [7:0] e;                    // Expected bit

  always #2.5 core_clk = ~core_clk;

  fifo_link_if link ();
  radio_data_fifo_pair radio_data_fifo_pair_i (.core_clk, .arst_n, .rx_write, .rx_write_data,
    .tx_read, .tx_read_data, .tx_empty, .sleep_enter, .general_output_pin, .link(link));
  fifo_host_ctrl fifo_host_ctrl_i (.core_clk, .arst_n, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .irq, .link(link));
  fifo_pair_monitor fifo_pair_monitor_i (.core_clk, .arst_n, .acc_valid(link.acc_valid),
    .acc_target(link.acc_target), .acc_wdata(link.acc_wdata),
    .buffer_threshold_select(link.buffer_threshold_select), .status_byte(link.status_byte),
    .rx_fill_count(link.rx_fill_count), .tx_fill_count(link.tx_fill_count),
    .rx_threshold(link.rx_threshold), .tx_threshold(link.tx_threshold),
    .rx_overflow_evt(link.rx_overflow_evt), .tx_underflow_evt(link.tx_underflow_evt));

  // Compare one byte result
  task automatic chk(input string nm, input logic [7:0] x, input logic [7:0] g);
    checks++;
    if (g !== x)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask

  // One-cycle register write
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask

  // Register read, masked compare in the cycle after the strobe
  task automatic rc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] x, input string nm);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1;
    chk(nm, x, reg_rdata & m);
  endtask

  // Radio pushes n bytes back to back
  task automatic push(input int n, input logic [7:0] b);
    for (int i = 0; i < n; i++)
    begin
      @(posedge core_clk);
      rx_write <= 1'b1;
      rx_write_data <= b + 8'(i);
    end
    @(posedge core_clk);
    rx_write <= 1'b0;
  endtask

  // Radio pops one byte and checks it
  task automatic pop(input logic [7:0] x);
    @(posedge core_clk);
    tx_read <= 1'b1;
    @(posedge core_clk);
    tx_read <= 1'b0;
    #1;
    chk("tx byte", x, tx_read_data);
  endtask

  // Let registered outputs settle
  task automatic settle();
    repeat (3) @(posedge core_clk);
    #1;
  endtask

  // Counts and verdict
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Cut a hang short
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc > 60000)
    begin
      err_count++;
      final_report();
    end
  end

  initial
  begin
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    // Reset state and unmapped read
    rc(`REG_CONFIG, 8'hFF, 8'h00, "config");
    rc(`REG_RX_COUNT, 8'hFF, 8'h00, "rx count");
    rc(`REG_TX_COUNT, 8'hFF, 8'h00, "tx count");
    rc(4'hF, 8'hFF, 8'h00, "unmapped");
    chk("tx empty", 8'h01, {7'h00, tx_empty});
    chk("irq", 8'h00, {7'h00, irq});
    $display("test reset done");
    // Receive path: threshold 8 on the pin, in-order drain
    wr(`REG_CONFIG, 8'h01);
    wr(`REG_IRQ_MASK, 8'h04);
    push(7, 8'h10);
    settle();
    chk("pin", 8'h00, {7'h00, general_output_pin});
    push(1, 8'h17);
    settle();
    chk("pin", 8'h01, {7'h00, general_output_pin});
    chk("irq", 8'h01, {7'h00, irq});
    rc(`REG_RX_COUNT, 8'hFF, 8'h08, "rx count");
    rc(`REG_RX_COUNT, 8'hFF, 8'h08, "rx count");
    for (int i = 0; i < 8; i++)
      rc(`REG_RX_DATA, 8'hFF, 8'h10 + 8'(i), "rx byte");
    rc(`REG_RX_COUNT, 8'hFF, 8'h00, "rx count");
    chk("pin", 8'h00, {7'h00, general_output_pin});
    wr(`REG_IRQ_STATUS, 8'h0F);
    wr(`REG_IRQ_MASK, 8'h00);
    #1;
    chk("irq", 8'h00, {7'h00, irq});
    $display("test rx path done");
    // Every threshold point and both threshold pin sources
    push(36, 8'h00);
    for (int i = 0; i < 29; i++)
      wr(`REG_TX_DATA, 8'(i));
    for (int n = 0; n < 16; n++)
      for (int s = 0; s < 2; s++)
      begin
        wr(`REG_CONFIG, {2'b00, 2'(s), 4'(n)});
        settle();
        e = 8'(s == 1 ? 29 >= 61 - 4 * n : 36 >= 4 * n + 4);
        chk("pin", e, {7'h00, general_output_pin});
        chk("rx thr", 8'(36 >= 4 * n + 4), {7'h00, link.rx_threshold});
        chk("tx thr", 8'(29 >= 61 - 4 * n), {7'h00, link.tx_threshold});
      end
    // Both flags drop one byte below the point
    wr(`REG_CONFIG, 8'h08);
    wr(`REG_IRQ_STATUS, 8'h0F);
    wr(`REG_IRQ_MASK, 8'h08);
    rc(`REG_RX_DATA, 8'hFF, 8'h00, "rx byte");
    pop(8'h00);
    settle();
    chk("rx thr", 8'h00, {7'h00, link.rx_threshold});
    chk("tx thr", 8'h00, {7'h00, link.tx_threshold});
    chk("irq", 8'h01, {7'h00, irq});
    rc(`REG_IRQ_STATUS, 8'h08, 8'h08, "irq status");
    $display("test thresholds done");
    // Sleep empties both buffers
    @(posedge core_clk);
    sleep_enter <= 1'b1;
    @(posedge core_clk);
    sleep_enter <= 1'b0;
    settle();
    rc(`REG_RX_COUNT, 8'hFF, 8'h00, "rx count");
    rc(`REG_TX_COUNT, 8'hFF, 8'h00, "tx count");
    chk("tx empty", 8'h01, {7'h00, tx_empty});
    wr(`REG_IRQ_STATUS, 8'h0F);
    wr(`REG_IRQ_MASK, 8'h00);
    $display("test sleep done");
    // Receive overflow, masking, flush and clear
    push(65, 8'h40);
    rc(`REG_IRQ_STATUS, 8'h01, 8'h01, "irq status");
    chk("irq", 8'h00, {7'h00, irq});
    wr(`REG_IRQ_MASK, 8'h01);
    #1;
    chk("irq", 8'h01, {7'h00, irq});
    rc(`REG_RX_COUNT, 8'hFF, 8'h40, "rx count");
    rc(`REG_RX_DATA, 8'hFF, 8'h40, "rx byte");
    rc(`REG_STATUS_BYTE, 8'h80, 8'h80, "status err");
    // Overflow flag routed onto the pin, then cleared by the flush
    wr(`REG_CONFIG, 8'h28);
    settle();
    chk("pin", 8'h01, {7'h00, general_output_pin});
    wr(`REG_COMMAND, 8'h01);
    rc(`REG_RX_COUNT, 8'hFF, 8'h00, "rx count");
    chk("pin", 8'h00, {7'h00, general_output_pin});
    wr(`REG_IRQ_STATUS, 8'h0F);
    #1;
    chk("irq", 8'h00, {7'h00, irq});
    wr(`REG_IRQ_MASK, 8'h00);
    $display("test overflow done");
    // Transmit path and underflow
    for (int i = 0; i < 3; i++)
      wr(`REG_TX_DATA, 8'hA0 + 8'(i));
    rc(`REG_TX_COUNT, 8'hFF, 8'h03, "tx count");
    chk("tx empty", 8'h00, {7'h00, tx_empty});
    for (int i = 0; i < 3; i++)
      pop(8'hA0 + 8'(i));
    chk("tx empty", 8'h01, {7'h00, tx_empty});
    pop(8'hA2);
    rc(`REG_IRQ_STATUS, 8'h02, 8'h02, "irq status");
    // Underflow flag on the pin, then a transmit flush empties and clears
    wr(`REG_CONFIG, 8'h38);
    settle();
    chk("pin", 8'h01, {7'h00, general_output_pin});
    wr(`REG_TX_DATA, 8'h55);
    wr(`REG_COMMAND, 8'h02);
    rc(`REG_TX_COUNT, 8'hFF, 8'h00, "tx count");
    chk("pin", 8'h00, {7'h00, general_output_pin});
    $display("test underflow done");
    final_report();
  end
endmodule
`default_nettype wire
